// [hw/cbwsc_defs.svh]
`ifndef CBWSC_DEFS_SVH
`define CBWSC_DEFS_SVH

// timing
`define CBWSC_CLK_PERIOD_NS 25
`define CBWSC_IO_GAP_MIN_NS 500
`define CBWSC_IO_GAP_MAX_NS 700
// least time, so round up to whole clocks
`define CBWSC_IO_GAP_CYC \
    ((`CBWSC_IO_GAP_MIN_NS + `CBWSC_CLK_PERIOD_NS - 1) / `CBWSC_CLK_PERIOD_NS)
`define CBWSC_GAP_CNT_W 5

// wait-state figures
`define CBWSC_WAIT_W 3
`define CBWSC_STRETCH_WAITS 3'h2

// register byte offsets
`define CBWSC_ADDR_W 8
`define CBWSC_OFS_CONFIG 8'h00
`define CBWSC_OFS_MGR_PORT 8'h04
`define CBWSC_OFS_STATUS 8'h08
`define CBWSC_OFS_WAIT_COUNT 8'h0C

// config fields
`define CBWSC_CFG_SEL_A 0
`define CBWSC_CFG_SEL_B 1
`define CBWSC_CFG_STRETCH 2
`define CBWSC_CFG_IO_RECOVERY 3
`define CBWSC_CFG_MGR_RESET 4
`define CBWSC_CFG_W 5
`define CBWSC_CFG_RESET 5'h1C

// manager port
`define CBWSC_MGR_W 8
`define CBWSC_MGR_RESET 8'h00

// status fields
`define CBWSC_ST_FETCH_WAITS 0
`define CBWSC_ST_MEM_WAITS 2
`define CBWSC_ST_STATE 4
`define CBWSC_ST_GAP_BUSY 8
`define CBWSC_ST_BUS_RDY 9
`define CBWSC_ST_SYS_RST 10

// axi responses
`define CBWSC_RESP_OKAY 2'h0
`define CBWSC_RESP_DECERR 2'h3

`endif

// [hw/cbwsc_gap_if.sv]
`timescale 1ns/1ps

interface cbwsc_gap_if;
    logic start;
    logic enable;
    logic busy;

    modport master (output start, output enable, input busy);
    modport gap (input start, input enable, output busy);
endinterface

// [hw/cbwsc_io_gap.sv]
`timescale 1ns/1ps
`include "cbwsc_defs.svh"

module cbwsc_io_gap (
    input wire logic clk,
    input wire logic rst_n,
    cbwsc_gap_if.gap gp
);

    localparam logic [`CBWSC_GAP_CNT_W-1:0] GAP_LOAD =
        `CBWSC_GAP_CNT_W'(`CBWSC_IO_GAP_CYC);

    logic [`CBWSC_GAP_CNT_W-1:0] cnt_r;
    logic [`CBWSC_GAP_CNT_W-1:0] cnt_nxt;

    // dropping the option frees a pending gap at once
    always_comb begin
        cnt_nxt = cnt_r;
        if (!gp.enable) begin
            cnt_nxt = '0;
        end else if (gp.start) begin
            cnt_nxt = GAP_LOAD;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign gp.busy = (cnt_r != '0);

endmodule

// [hw/cbwsc_pkg.sv]
package cbwsc_pkg;

    typedef enum logic [1:0] {
        CBWSC_KIND_FETCH,
        CBWSC_KIND_MEM_READ,
        CBWSC_KIND_MEM_WRITE,
        CBWSC_KIND_IO
    } cbwsc_kind_e;

    typedef enum logic [1:0] {
        CBWSC_IDLE,
        CBWSC_GAP,
        CBWSC_WAIT
    } cbwsc_state_e;

endpackage

// [hw/cbwsc_top.sv]
// Functional notes
// - The two selectors map right/right to 0/0, right/left to 1/0, left/right to 1/1 and left/left to 2/1 fetch/memory waits.
// - Fetch cycles get 0 to 2 waits, set by both selectors, and other memory cycles 0 to 1, set by the first selector alone.
// - With the stretch option on, memory data reads get two extra waits, fetches never do; off, none are added.
// - With the recovery option on, consecutive I/O cycles are kept at least 500 ns apart; off, they run back to back.
// - With the reset option at its default, the manager port clears to zero at power-on and while system reset is active.
`timescale 1ns/1ps
`include "cbwsc_defs.svh"

module cbwsc_top (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic CYC_START,
    input wire logic [1:0] CYC_KIND,
    input wire logic BUS_RDY,
    input wire logic SYS_RESET_N,
    output logic CPU_READY,
    output logic [`CBWSC_MGR_W-1:0] MGR_PORT,
    input wire logic [`CBWSC_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [`CBWSC_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    // pin synchronisers
    logic bus_rdy_m_r;
    logic bus_rdy_s_r;
    logic sys_rst_m_r;
    logic sys_rst_s_r;

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            bus_rdy_m_r <= 1'b0;
            bus_rdy_s_r <= 1'b0;
            sys_rst_m_r <= 1'b0;
            sys_rst_s_r <= 1'b0;
        end else begin
            bus_rdy_m_r <= BUS_RDY;
            bus_rdy_s_r <= bus_rdy_m_r;
            sys_rst_m_r <= ~SYS_RESET_N;
            sys_rst_s_r <= sys_rst_m_r;
        end
    end

    // configuration
    logic [`CBWSC_CFG_W-1:0] cfg_r;
    logic [`CBWSC_MGR_W-1:0] mgr_r;
    logic [31:0] wait_count_r;

    wire sel_a = cfg_r[`CBWSC_CFG_SEL_A];
    wire sel_b = cfg_r[`CBWSC_CFG_SEL_B];
    wire stretch_on = cfg_r[`CBWSC_CFG_STRETCH];
    wire io_recovery_on = cfg_r[`CBWSC_CFG_IO_RECOVERY];
    wire mgr_reset_on = cfg_r[`CBWSC_CFG_MGR_RESET];

    // selector set 1 means left, 0 means right
    wire [1:0] fetch_waits = {sel_a & sel_b, sel_a ^ sel_b};
    wire mem_wait = sel_a;

    // waits for the cycle being started
    cbwsc_pkg::cbwsc_kind_e kind_in;
    assign kind_in = cbwsc_pkg::cbwsc_kind_e'(CYC_KIND);

    wire [`CBWSC_WAIT_W-1:0] fetch_w = {1'b0, fetch_waits};
    wire [`CBWSC_WAIT_W-1:0] mem_w = {2'b00, mem_wait};
    wire [`CBWSC_WAIT_W-1:0] stretch_w =
        stretch_on ? `CBWSC_STRETCH_WAITS : '0;
    wire [`CBWSC_WAIT_W-1:0] rd_w = mem_w + stretch_w;

    logic [`CBWSC_WAIT_W-1:0] waits_in;
    always_comb begin
        case (kind_in)
            cbwsc_pkg::CBWSC_KIND_FETCH: waits_in = fetch_w;
            cbwsc_pkg::CBWSC_KIND_MEM_READ: waits_in = rd_w;
            cbwsc_pkg::CBWSC_KIND_MEM_WRITE: waits_in = mem_w;
            default: waits_in = '0;
        endcase
    end

    // cycle sequencer
    cbwsc_gap_if gap_if ();

    cbwsc_io_gap u_gap (
        .clk(REF_CLK),
        .rst_n(NRST),
        .gp(gap_if.gap)
    );

    cbwsc_pkg::cbwsc_state_e state_r;
    cbwsc_pkg::cbwsc_state_e state_nxt;
    logic [`CBWSC_WAIT_W-1:0] cnt_r;
    logic [`CBWSC_WAIT_W-1:0] cnt_nxt;

    wire is_idle = (state_r == cbwsc_pkg::CBWSC_IDLE);
    wire in_wait = (state_r == cbwsc_pkg::CBWSC_WAIT);
    wire in_gap = (state_r == cbwsc_pkg::CBWSC_GAP);
    wire start_io = CYC_START && (kind_in == cbwsc_pkg::CBWSC_KIND_IO);
    wire io_blocked = start_io && gap_if.busy;
    // the last counted wait only ends once the bus itself is ready
    wire last_wait = in_wait && (cnt_r == 3'h1) && bus_rdy_s_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            cbwsc_pkg::CBWSC_IDLE: begin
                if (CYC_START && io_blocked) begin
                    state_nxt = cbwsc_pkg::CBWSC_GAP;
                end else if (CYC_START && waits_in != '0) begin
                    state_nxt = cbwsc_pkg::CBWSC_WAIT;
                    cnt_nxt = waits_in;
                end
            end
            cbwsc_pkg::CBWSC_GAP: begin
                if (!gap_if.busy) begin
                    state_nxt = cbwsc_pkg::CBWSC_IDLE;
                end
            end
            cbwsc_pkg::CBWSC_WAIT: begin
                if (last_wait) begin
                    state_nxt = cbwsc_pkg::CBWSC_IDLE;
                    cnt_nxt = '0;
                end else if (cnt_r != 3'h1) begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                state_nxt = cbwsc_pkg::CBWSC_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state_r <= cbwsc_pkg::CBWSC_IDLE;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // io cycles carry no waits, so they end on their start edge
    // or on the edge that closes a pending gap
    assign gap_if.start = (is_idle && start_io && !gap_if.busy)
        || (in_gap && !gap_if.busy);
    assign gap_if.enable = io_recovery_on;

    // ready low for one clock per counted wait, and while the bus holds
    assign CPU_READY = is_idle && bus_rdy_s_r;

    // register bus: write side
    logic aw_held_r;
    logic [`CBWSC_ADDR_W-1:0] aw_addr_r;
    logic w_held_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;

    assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
    assign S_AXI_WREADY = !w_held_r && !bvalid_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;

    wire do_write = aw_held_r && w_held_r && !bvalid_r;
    wire [`CBWSC_ADDR_W-1:0] wa = {aw_addr_r[`CBWSC_ADDR_W-1:2], 2'b00};
    wire wr_cfg = do_write && (wa == `CBWSC_OFS_CONFIG);
    wire wr_mgr = do_write && (wa == `CBWSC_OFS_MGR_PORT);
    wire wr_cnt = do_write && (wa == `CBWSC_OFS_WAIT_COUNT);
    wire wr_stat = do_write && (wa == `CBWSC_OFS_STATUS);
    wire wr_hit = wr_cfg || wr_mgr || wr_cnt || wr_stat;
    wire lane0 = w_strb_r[0];

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_held_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            bvalid_r <= 1'b0;
            bresp_r <= `CBWSC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? `CBWSC_RESP_OKAY : `CBWSC_RESP_DECERR;
        end else if (S_AXI_BREADY) begin
            bvalid_r <= 1'b0;
        end
    end

    // software-written registers
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            cfg_r <= `CBWSC_CFG_RESET;
        end else if (wr_cfg && lane0) begin
            cfg_r <= w_data_r[`CBWSC_CFG_W-1:0];
        end
    end

    // power-on clears through NRST; system reset clears only when enabled
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            mgr_r <= `CBWSC_MGR_RESET;
        end else if (sys_rst_s_r && mgr_reset_on) begin
            mgr_r <= `CBWSC_MGR_RESET;
        end else if (wr_mgr && lane0) begin
            mgr_r <= w_data_r[`CBWSC_MGR_W-1:0];
        end
    end

    assign MGR_PORT = mgr_r;

    // wait clocks counted; a wait in the clearing cycle still counts
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            wait_count_r <= '0;
        end else if (wr_cnt) begin
            wait_count_r <= {31'h0, in_wait};
        end else if (in_wait && wait_count_r != 32'hFFFFFFFF) begin
            wait_count_r <= wait_count_r + 32'h1;
        end
    end

    // register bus: read side
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    wire [`CBWSC_ADDR_W-1:0] ra = {S_AXI_ARADDR[`CBWSC_ADDR_W-1:2], 2'b00};
    wire rd_cfg = (ra == `CBWSC_OFS_CONFIG);
    wire rd_mgr = (ra == `CBWSC_OFS_MGR_PORT);
    wire rd_stat = (ra == `CBWSC_OFS_STATUS);
    wire rd_cnt = (ra == `CBWSC_OFS_WAIT_COUNT);
    wire rd_hit = rd_cfg || rd_mgr || rd_stat || rd_cnt;

    logic [31:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[`CBWSC_ST_FETCH_WAITS +: 2] = fetch_waits;
        status_word[`CBWSC_ST_MEM_WAITS] = mem_wait;
        status_word[`CBWSC_ST_STATE +: 2] = state_r;
        status_word[`CBWSC_ST_GAP_BUSY] = gap_if.busy;
        status_word[`CBWSC_ST_BUS_RDY] = bus_rdy_s_r;
        status_word[`CBWSC_ST_SYS_RST] = sys_rst_s_r;
    end

    wire [31:0] rd_mux =
        rd_cfg ? {27'h0, cfg_r} :
        rd_mgr ? {24'h0, mgr_r} :
        rd_stat ? status_word :
        rd_cnt ? wait_count_r : 32'h0;

    assign S_AXI_ARREADY = !rvalid_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= `CBWSC_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? `CBWSC_RESP_OKAY : `CBWSC_RESP_DECERR;
        end else if (S_AXI_RREADY) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule

// [test/cbwsc_bus_board.sv]
`timescale 1ns/1ps

module cbwsc_bus_board (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cyc_start,
    input wire logic cpu_ready,
    input wire logic slow,
    output logic bus_rdy
);
    // a slow board adds exactly one wait per taken cycle, never more
    wire logic take = slow && cyc_start && cpu_ready;
    // released line sits at its pull-up level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            bus_rdy <= 1'b1;
        else
            bus_rdy <= !take;
    end
endmodule

// [test/cbwsc_properties.sv]
`timescale 1ns/1ps
`include "cbwsc_defs.svh"

module cbwsc_properties (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic CYC_START,
    input wire logic [1:0] CYC_KIND,
    input wire logic SYS_RESET_N,
    input wire logic CPU_READY,
    input wire logic [`CBWSC_MGR_W-1:0] MGR_PORT,
    input wire logic [`CBWSC_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    // shadow only holds because the bench offers address and data together
    logic [`CBWSC_CFG_W-1:0] cfg_r;
    wire logic cfg_wr = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY && S_AXI_WSTRB[0]
        && S_AXI_AWADDR == `CBWSC_OFS_CONFIG;
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST)
            cfg_r <= `CBWSC_CFG_RESET;
        else if (cfg_wr)
            cfg_r <= S_AXI_WDATA[`CBWSC_CFG_W-1:0];
    end

    sequence s_take(logic [1:0] k);
        CYC_START && CPU_READY && CYC_KIND == k;
    endsequence
    sequence s_low16;
        !CPU_READY [*8] ##1 !CPU_READY [*8];
    endsequence

    a_mgr_clear_rst: assert property (
        $rose(NRST) |-> MGR_PORT == 8'h00)
        else $error("manager port not clear after reset");
    a_mgr_sys_rst: assert property (
        (cfg_r[`CBWSC_CFG_MGR_RESET] && !SYS_RESET_N) [*3]
        |=> MGR_PORT == 8'h00)
        else $error("manager port kept during system reset");
    a_fetch_two_waits: assert property (
        s_take(2'h0) ##0 cfg_r[1:0] == 2'h3 |=> !CPU_READY [*2])
        else $error("fetch did not get two waits");
    a_mem_one_wait: assert property (
        s_take(2'h2) ##0 cfg_r[`CBWSC_CFG_SEL_A] |=> !CPU_READY)
        else $error("memory write did not get its wait");
    a_read_stretch: assert property (
        s_take(2'h1) ##0 cfg_r[`CBWSC_CFG_STRETCH] |=> !CPU_READY [*2])
        else $error("data read not stretched");
    a_io_rest_gap: assert property (
        s_take(2'h3) ##0 cfg_r[`CBWSC_CFG_IO_RECOVERY]
        ##1 (CYC_START && CYC_KIND == 2'h3) |=> s_low16)
        else $error("second io cycle ran inside rest gap");
    a_ready_returns: assert property (
        $fell(CPU_READY) |-> ##[1:40] CPU_READY)
        else $error("ready not released");
    a_read_answer: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read not answered");
    a_write_block: assert property (
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write accepted while response pending");
endmodule

bind cbwsc_top cbwsc_properties cbwsc_properties_i (
    .REF_CLK(REF_CLK), .NRST(NRST), .CYC_START(CYC_START),
    .CYC_KIND(CYC_KIND), .SYS_RESET_N(SYS_RESET_N),
    .CPU_READY(CPU_READY), .MGR_PORT(MGR_PORT),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID));

// [test/cbwsc_top_tb.sv]
`timescale 1ns/1ps
`include "cbwsc_defs.svh"

module cbwsc_top_tb;
    logic REF_CLK = 1'b0;
    logic NRST = 1'b0;
    logic CYC_START = 1'b0;
    logic [1:0] CYC_KIND = 2'h0;
    logic SYS_RESET_N = 1'b1;
    logic slow = 1'b0;
    logic BUS_RDY, CPU_READY;
    logic [7:0] MGR_PORT;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int n_errors = 0;
    int num_checks = 0;

    always #12.5 REF_CLK = ~REF_CLK;

    cbwsc_top cbwsc_top_i (
        .REF_CLK(REF_CLK), .NRST(NRST), .CYC_START(CYC_START),
        .CYC_KIND(CYC_KIND), .BUS_RDY(BUS_RDY), .SYS_RESET_N(SYS_RESET_N),
        .CPU_READY(CPU_READY), .MGR_PORT(MGR_PORT),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    cbwsc_bus_board cbwsc_bus_board_i (
        .clk(REF_CLK), .rst_n(NRST), .cyc_start(CYC_START),
        .cpu_ready(CPU_READY), .slow(slow), .bus_rdy(BUS_RDY));

    task automatic final_report;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic hang;
        n_errors++;
        final_report();
    endtask

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic axi_wr(logic [7:0] a, logic [31:0] d,
                          output logic [1:0] r);
        @(posedge REF_CLK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (50) begin
            @(posedge REF_CLK);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        hang();
    endtask

    task automatic axi_rd(logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge REF_CLK);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (50) begin
            @(posedge REF_CLK);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                return;
            end
        end
        hang();
    endtask

    task automatic set_cfg(logic [4:0] c);
        logic [1:0] r;
        axi_wr(`CBWSC_OFS_CONFIG, {27'h0, c}, r);
        check(r, `CBWSC_RESP_OKAY);
    endtask

    task automatic wait_ready;
        repeat (100) begin
            @(negedge REF_CLK);
            if (CPU_READY === 1'b1)
                return;
        end
        hang();
    endtask

    // counts low clocks of ready after the take edge
    task automatic count(output int n);
        n = 0;
        repeat (60) begin
            @(negedge REF_CLK);
            if (CPU_READY === 1'b1)
                return;
            n++;
        end
        hang();
    endtask

    task automatic run_cyc(logic [1:0] k, output int n);
        wait_ready();
        @(posedge REF_CLK);
        CYC_START <= 1'b1;
        CYC_KIND <= k;
        @(posedge REF_CLK);
        CYC_START <= 1'b0;
        count(n);
    endtask

    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(`CBWSC_OFS_CONFIG, d, r);
        check(d, `CBWSC_CFG_RESET);
        check(MGR_PORT, 8'h00);
        axi_rd(8'h10, d, r);
        check(r, `CBWSC_RESP_DECERR);
        axi_wr(8'h10, 32'h0, r);
        check(r, `CBWSC_RESP_DECERR);
        $display("t_regs done");
    endtask

    task automatic t_waits;
        int n;
        int fw[4] = '{0, 1, 1, 2};
        int mw[4] = '{0, 1, 0, 1};
        for (int s = 0; s < 4; s++) begin
            set_cfg({3'h4, s[1:0]});
            run_cyc(2'h0, n);
            check(n, fw[s]);
            run_cyc(2'h1, n);
            check(n, mw[s]);
            run_cyc(2'h2, n);
            check(n, mw[s]);
            run_cyc(2'h3, n);
            check(n, 0);
        end
        $display("t_waits done");
    endtask

    task automatic t_stretch;
        int n;
        logic [31:0] d;
        logic [1:0] r;
        set_cfg(5'h17);
        axi_wr(`CBWSC_OFS_WAIT_COUNT, 32'h0, r);
        run_cyc(2'h1, n);
        check(n, 3);
        axi_rd(`CBWSC_OFS_WAIT_COUNT, d, r);
        check(d, 32'h3);
        run_cyc(2'h0, n);
        check(n, 2);
        run_cyc(2'h2, n);
        check(n, 1);
        set_cfg(5'h14);
        run_cyc(2'h1, n);
        check(n, 2);
        $display("t_stretch done");
    endtask

    // two io starts on adjacent edges
    task automatic t_io;
        int n;
        for (int e = 0; e < 2; e++) begin
            set_cfg({1'b1, e[0], 3'h0});
            wait_ready();
            @(posedge REF_CLK);
            CYC_START <= 1'b1;
            CYC_KIND <= 2'h3;
            repeat (2) @(posedge REF_CLK);
            CYC_START <= 1'b0;
            count(n);
            // spacing is n+1 clocks: 500 ns to 700 ns at 25 ns
            check(e ? (n >= 19 && n <= 27) : n == 0, 1'b1);
        end
        $display("t_io done");
    endtask

    task automatic t_slow;
        int n;
        set_cfg(5'h13);
        slow <= 1'b1;
        run_cyc(2'h0, n);
        check(n, 3);
        slow <= 1'b0;
        $display("t_slow done");
    endtask

    task automatic t_sysrst;
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(`CBWSC_OFS_MGR_PORT, 32'hA5, r);
        axi_rd(`CBWSC_OFS_MGR_PORT, d, r);
        check(d, 32'hA5);
        @(posedge REF_CLK);
        SYS_RESET_N <= 1'b0;
        repeat (5) @(posedge REF_CLK);
        SYS_RESET_N <= 1'b1;
        check(MGR_PORT, 8'h00);
        axi_rd(`CBWSC_OFS_MGR_PORT, d, r);
        check(d, 32'h0);
        // option moved off: system reset must leave the port alone
        set_cfg(5'h03);
        axi_wr(`CBWSC_OFS_MGR_PORT, 32'h5A, r);
        check(r, `CBWSC_RESP_OKAY);
        @(posedge REF_CLK);
        SYS_RESET_N <= 1'b0;
        repeat (5) @(posedge REF_CLK);
        SYS_RESET_N <= 1'b1;
        check(MGR_PORT, 8'h5A);
        // power-on clears whatever the option says
        @(posedge REF_CLK);
        NRST <= 1'b0;
        repeat (3) @(posedge REF_CLK);
        check(MGR_PORT, 8'h00);
        NRST <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        check(MGR_PORT, 8'h00);
        $display("t_sysrst done");
    endtask

    initial begin
        repeat (20) @(posedge REF_CLK);
        NRST <= 1'b1;
        t_regs();
        t_waits();
        t_stretch();
        t_io();
        t_slow();
        t_sysrst();
        final_report();
    end
endmodule
